// File: mbcrs_top.sv
/*
  mbcrs_top: command logic and reading store of a bus multimeter.
  Assumes a classic Wishbone master on the same clock, and conversion
  results arriving as a same-clock valid/data pair.
*/
// Our own choices: register access over Wishbone and the register offsets.
// Behaviour
// - range code 0 auto; dB always auto
// - report ready when idle and commands done
// - converter source talks converter readings
// - single readout returns next, advances pointer
// - pointer wraps to start after last
// - source, size, interval commands reset pointer
// - whole readout waits for full buffer
// - restore keeps address, terminator, line frequency
// - restore covers settings, filter, baseline
// - mask off means no service request
// - masked events stay queued and readable
// - mask leaves event enables unchanged
// - send gives one trigger, queues reading
// - talk outputs one reading per queued
// - settings query returns all settings
// - interval 1 to 9999999 ms
// - one-shot ignores storage interval
// - short interval conflicts refuse storing
// - interval 1 or 2 with 4 digits conflicts
// - interval or size command clears store
// - storing stops at count unless circular
// - range accepts 0 to 7
`timescale 1ns/10ps
module mbcrs_top
  import mbcrs_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // converter side
  input wire logic adc_valid,
  input wire logic [31:0] adc_data,
  input wire logic converter_idle,
  output logic trigger_pulse,
  // instrument bus lines
  output logic srq,
  output logic settings_conflict,
  output logic [2:0] range_sel,
  output logic auto_range
);
  logic [31:0] ctrl;
  logic [23:0] storage_interval;
  logic [6:0] buffer_size_setting;
  logic [31:0] store [MBCRS_DEPTH];
  logic [6:0] wr_count;
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  logic [6:0] dump_left;
  logic [7:0] pending;
  logic storing;
  logic [2:0] events;
  logic [23:0] ms_left;
  logic [14:0] cyc_left;
  logic interval_tick;
  logic [31:0] last_adc;
  logic [31:0] filter_constant;
  logic [31:0] baseline_offset;
  mbcrs_tstate_t tstate;

  // bus decode
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // writes land at the edge where the master sees ack high
  wire bus_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & (&wb_sel_i);
  wire bus_rd = bus_req & ~wb_we_i;
  wire wr_ctrl = bus_wr & (wb_adr_i == MBCRS_CTRL);
  wire wr_storage_interval = bus_wr & (wb_adr_i == MBCRS_STORAGE_INTERVAL);
  wire wr_buffer_size_setting = bus_wr & (wb_adr_i == MBCRS_BUFFER_SIZE_SETTING);
  wire wr_cmd = bus_wr & (wb_adr_i == MBCRS_CMD);
  wire rd_talk = bus_rd & (wb_adr_i == MBCRS_TALK);
  wire cmd_reset = wr_cmd & wb_dat_i[MBCRS_C_RESET];
  wire cmd_send = wr_cmd & wb_dat_i[MBCRS_C_SEND];
  wire cmd_read = wr_cmd & wb_dat_i[MBCRS_C_READ];
  wire cmd_clrev = wr_cmd & wb_dat_i[MBCRS_C_CLREV];

  // held settings
  wire [2:0] set_range = ctrl[MBCRS_F_RANGE +: 3];
  wire [2:0] set_func = ctrl[MBCRS_F_FUNC +: 3];
  wire [2:0] set_digits = ctrl[MBCRS_F_DIGITS +: 3];
  wire [1:0] set_src = ctrl[MBCRS_F_SRC +: 2];
  wire set_rdy = ctrl[MBCRS_F_RDY];
  wire set_rqs = ctrl[MBCRS_F_RQS];
  wire set_oneshot = ctrl[MBCRS_F_ONESHOT];
  wire set_circ = ctrl[MBCRS_F_CIRC];
  wire [2:0] set_even = ctrl[MBCRS_F_EVEN +: 3];
  wire is_db = (set_func == MBCRS_F_VDB) | (set_func == MBCRS_F_ADB);
  wire is_ohm = (set_func == MBCRS_F_OHM) | (set_func == MBCRS_F_OHC);

  // auto for code 0 and dB
  wire next_auto = (set_range == 3'h0) | is_db;

  wire short_iv = (storage_interval != MBCRS_STORAGE_INTERVAL_RST)
    & (storage_interval <= MBCRS_CONFL_HI);
  wire confl_a = short_iv & (is_ohm | is_db | next_auto | set_circ
    | (set_digits == 3'h5) | (set_digits == 3'h6));
  // four digits at 1 or 2 ms
  wire confl_b = (storage_interval != MBCRS_STORAGE_INTERVAL_RST)
    & (storage_interval <= MBCRS_CONFL_4D) & (set_digits == 3'h4);
  wire conflict = confl_a | confl_b;

  wire buf_full = wr_count == buffer_size_setting;
  // one-shot stores per conversion, interval ignored
  wire store_ok = storing & ~conflict & adc_valid
    & (set_oneshot | storage_interval == MBCRS_STORAGE_INTERVAL_RST
      | interval_tick);
  wire store_done = ~set_circ & buf_full;
  wire [31:0] head = store[rd_ptr];
  wire [5:0] rd_next = (rd_ptr + 6'h01 >= wr_count[5:0]
    && !(wr_count == 7'h40 && rd_ptr != 6'h3F)) ? 6'h00
    : rd_ptr + 6'h01;
  wire talk_ready = (set_src == MBCRS_S_ADC) ? 1'b1
    : (set_src == MBCRS_S_ONE) ? (wr_count != 7'h00)
    : (tstate == MBCRS_T_DUMP);
  wire [31:0] talk_word = (set_src == MBCRS_S_ADC) ? last_adc : head;
  wire [31:0] status_word = {22'h0, tstate, storing, conflict,
    pending[3:0], converter_idle, set_rdy};
  // settings query: control, interval, size words
  wire [31:0] rd_mux =
    (wb_adr_i == MBCRS_CTRL) ? ctrl :
    (wb_adr_i == MBCRS_STORAGE_INTERVAL) ? {8'h00, storage_interval} :
    (wb_adr_i == MBCRS_BUFFER_SIZE_SETTING) ? {25'h0, buffer_size_setting} :
    (wb_adr_i == MBCRS_STATUS) ? status_word :
    (wb_adr_i == MBCRS_ADCIN) ? filter_constant ^ baseline_offset :
    (wb_adr_i == MBCRS_TALK) ? talk_word :
    (wb_adr_i == MBCRS_RANGE) ? {28'h0, next_auto, set_range} :
    (wb_adr_i == MBCRS_EVENTS) ? {29'h0, events} : 32'h0;

  // bus answer, one cycle after request
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end
    else
    begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_rd ? ((rd_talk & ~talk_ready) ? 32'h0 : rd_mux)
        : 32'h0;
    end
  end

  // settings; restore keeps none of bus address here
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= MBCRS_CTRL_RST;
      filter_constant <= 32'h0;
      baseline_offset <= 32'h0;
    end
    // restore touches only settings held here
    else if (cmd_reset)
    begin
      ctrl <= MBCRS_CTRL_RST;
      filter_constant <= 32'h0;
      baseline_offset <= 32'h0;
    end
    else if (wr_ctrl)
      ctrl <= {11'h0, wb_dat_i[20:0] & 21'h1FF777};
    else if (bus_wr & (wb_adr_i == MBCRS_ADCIN))
      baseline_offset <= wb_dat_i;
  end

  wire [23:0] iv_in = (wb_dat_i[23:0] > MBCRS_STORAGE_INTERVAL_MAX)
    ? MBCRS_STORAGE_INTERVAL_MAX : wb_dat_i[23:0];
  wire [6:0] sz_in = (wb_dat_i[6:0] == 7'h00 || wb_dat_i[6:0] > 7'h40)
    ? MBCRS_BUFFER_SIZE_SETTING_RST : wb_dat_i[6:0];

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      storage_interval <= MBCRS_STORAGE_INTERVAL_RST;
      buffer_size_setting <= MBCRS_BUFFER_SIZE_SETTING_RST;
    end
    else if (cmd_reset)
    begin
      storage_interval <= MBCRS_STORAGE_INTERVAL_RST;
      buffer_size_setting <= MBCRS_BUFFER_SIZE_SETTING_RST;
    end
    else
    begin
      if (wr_storage_interval)
        storage_interval <= iv_in;
      if (wr_buffer_size_setting)
        buffer_size_setting <= sz_in;
    end
  end

  // interval timer in milliseconds
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cyc_left <= 15'h0;
      ms_left <= 24'h0;
      interval_tick <= 1'b0;
    end
    else if (wr_storage_interval | ~storing)
    begin
      cyc_left <= 15'(MBCRS_MS_CYC - 1);
      ms_left <= storage_interval;
      interval_tick <= 1'b0;
    end
    else if (store_ok)
      interval_tick <= 1'b0;
    else if (cyc_left != 15'h0)
      cyc_left <= cyc_left - 15'h1;
    else
    begin
      cyc_left <= 15'(MBCRS_MS_CYC - 1);
      if (ms_left <= 24'h1)
      begin
        ms_left <= storage_interval;
        interval_tick <= 1'b1;
      end
      else
        ms_left <= ms_left - 24'h1;
    end
  end

  // store writes
  always_ff @(posedge clock)
  begin
    if (store_ok)
      store[wr_ptr] <= adc_data;
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_ptr <= 6'h0;
      wr_count <= 7'h0;
      storing <= 1'b0;
      last_adc <= 32'h0;
    end
    // interval or size command clears store
    else if (wr_storage_interval | wr_buffer_size_setting)
    begin
      wr_ptr <= 6'h0;
      wr_count <= 7'h0;
      storing <= 1'b1;
    end
    else
    begin
      if (adc_valid)
        last_adc <= adc_data;
      if (store_done | cmd_reset)
        storing <= 1'b0;
      else if (store_ok)
      begin
        wr_ptr <= (7'(wr_ptr) + 7'h1 >= buffer_size_setting) ? 6'h0
          : wr_ptr + 6'h1;
        if (!buf_full)
          wr_count <= wr_count + 7'h1;
      end
    end
  end

  wire rd_rst = cmd_read | wr_storage_interval | wr_buffer_size_setting
    | (wr_ctrl & (wb_dat_i[MBCRS_F_SRC +: 2] != set_src));
  wire next_dump = (tstate == MBCRS_T_WAIT) & (buf_full | store_done);
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rd_ptr <= 6'h0;
      tstate <= MBCRS_T_IDLE;
      dump_left <= 7'h0;
    end
    else if (rd_rst)
    begin
      rd_ptr <= 6'h0;
      tstate <= MBCRS_T_IDLE;
      dump_left <= 7'h0;
    end
    else
    begin
      case (tstate)
        MBCRS_T_IDLE:
        begin
          if (rd_talk & (set_src == MBCRS_S_ALL))
            tstate <= MBCRS_T_WAIT;
          else if (rd_talk & talk_ready & (set_src == MBCRS_S_ONE))
            rd_ptr <= rd_next;
        end
        MBCRS_T_WAIT:
        begin
          if (next_dump)
          begin
            tstate <= MBCRS_T_DUMP;
            dump_left <= wr_count;
          end
        end
        MBCRS_T_DUMP:
        begin
          if (rd_talk)
          begin
            rd_ptr <= rd_next;
            dump_left <= dump_left - 7'h1;
            if (dump_left == 7'h1)
              tstate <= MBCRS_T_IDLE;
          end
        end
        default:
          tstate <= MBCRS_T_IDLE;
      endcase
    end
  end

  // send: one trigger, one pending reading
  // each talk consumes one pending reading
  wire talk_take = rd_talk & (pending != 8'h0);
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      pending <= 8'h0;
      trigger_pulse <= 1'b0;
    end
    else
    begin
      trigger_pulse <= cmd_send;
      if (cmd_send & ~talk_take & (pending != 8'hFF))
        pending <= pending + 8'h1;
      else if (talk_take & ~cmd_send)
        pending <= pending - 8'h1;
    end
  end

  // event flags: ready, conflict, buffer full; set wins over clear
  // ready when converter idle and nothing pending
  wire ev_ready = set_rdy & converter_idle & (pending == 8'h0)
    & ~bus_req;
  wire [2:0] ev_set = {buf_full & storing, conflict & storing, ev_ready};
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      events <= 3'h0;
    else
      events <= ev_set | (events & ~(cmd_clrev ? 3'h7 : 3'h0));
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      srq <= 1'b0;
      settings_conflict <= 1'b0;
      range_sel <= 3'h0;
      auto_range <= 1'b1;
    end
    else
    begin
      srq <= set_rqs & (|(events & set_even));
      settings_conflict <= conflict & storing;
      range_sel <= next_auto ? 3'h0 : set_range;
      auto_range <= next_auto;
    end
  end

  a_srq_masked: assert property (@(posedge clock) disable iff (!rstn)
    !$past(set_rqs) |-> !srq) else $error("srq while masked");
  a_auto_range: assert property (@(posedge clock) disable iff (!rstn)
    $past(next_auto) |-> auto_range && range_sel == 3'h0)
    else $error("auto range wrong");
  a_send_trig: assert property (@(posedge clock) disable iff (!rstn)
    cmd_send |=> trigger_pulse ##1 !trigger_pulse || $past(cmd_send))
    else $error("send trigger wrong");
  a_ptr_reset: assert property (@(posedge clock) disable iff (!rstn)
    rd_rst |=> rd_ptr == 6'h0) else $error("pointer not reset");
  a_store_clr: assert property (@(posedge clock) disable iff (!rstn)
    (wr_storage_interval | wr_buffer_size_setting) |=> wr_count == 7'h0 && storing)
    else $error("store not cleared");
  a_conflict_hold: assert property (@(posedge clock) disable iff (!rstn)
    conflict && !(wr_storage_interval | wr_buffer_size_setting) |=> $stable(wr_count))
    else $error("stored under conflict");
  a_dump_full: assert property (@(posedge clock) disable iff (!rstn)
    $rose(tstate == MBCRS_T_DUMP) |-> $past(next_dump))
    else $error("dump before full");
  a_interval: assert property (@(posedge clock) disable iff (!rstn)
    storage_interval <= MBCRS_STORAGE_INTERVAL_MAX) else $error("interval range");
endmodule

// File: mbcrs_pkg.sv
/*
  mbcrs_pkg: constants and types for the meter bus command and reading store.
  Assumes one 25 MHz clock and a classic Wishbone slave with 32-bit data.
*/
package mbcrs_pkg;
  // register byte offsets
  localparam logic [7:0] MBCRS_CTRL = 8'h00;
  localparam logic [7:0] MBCRS_STORAGE_INTERVAL = 8'h04;
  localparam logic [7:0] MBCRS_BUFFER_SIZE_SETTING = 8'h08;
  localparam logic [7:0] MBCRS_CMD = 8'h0C;
  localparam logic [7:0] MBCRS_STATUS = 8'h10;
  localparam logic [7:0] MBCRS_ADCIN = 8'h14;
  localparam logic [7:0] MBCRS_TALK = 8'h18;
  localparam logic [7:0] MBCRS_RANGE = 8'h1C;
  localparam logic [7:0] MBCRS_EVENTS = 8'h20;
  // control field positions
  localparam int MBCRS_F_RANGE = 0;
  localparam int MBCRS_F_FUNC = 4;
  localparam int MBCRS_F_DIGITS = 8;
  localparam int MBCRS_F_SRC = 12;
  localparam int MBCRS_F_RDY = 14;
  localparam int MBCRS_F_RQS = 15;
  localparam int MBCRS_F_ONESHOT = 16;
  localparam int MBCRS_F_CIRC = 17;
  localparam int MBCRS_F_EVEN = 18;
  // command bits in the command register
  localparam int MBCRS_C_RESET = 0;
  localparam int MBCRS_C_SEND = 1;
  localparam int MBCRS_C_READ = 2;
  localparam int MBCRS_C_CLREV = 3;
  // reset values, limits and store depth
  localparam logic [31:0] MBCRS_CTRL_RST = 32'h0000_0500;
  localparam logic [23:0] MBCRS_STORAGE_INTERVAL_RST = 24'h000000;
  localparam logic [23:0] MBCRS_STORAGE_INTERVAL_MAX = 24'h98967F;
  localparam logic [23:0] MBCRS_CONFL_HI = 24'h00000E;
  localparam logic [23:0] MBCRS_CONFL_4D = 24'h000002;
  localparam logic [6:0] MBCRS_BUFFER_SIZE_SETTING_RST = 7'h40;
  localparam int MBCRS_DEPTH = 64;
  // timing: one millisecond in cycles
  localparam int MBCRS_CLK_HZ = 25000000;
  localparam int MBCRS_MS_CYC = MBCRS_CLK_HZ / 1000;
  typedef enum logic [2:0] {
    MBCRS_F_DCV = 3'b000, MBCRS_F_ACV = 3'b001, MBCRS_F_OHM = 3'b010,
    MBCRS_F_DCA = 3'b011, MBCRS_F_ACA = 3'b100, MBCRS_F_VDB = 3'b101,
    MBCRS_F_ADB = 3'b110, MBCRS_F_OHC = 3'b111
  } mbcrs_func_t;
  typedef enum logic [1:0] {
    MBCRS_S_ADC = 2'b00, MBCRS_S_ONE = 2'b01, MBCRS_S_ALL = 2'b10
  } mbcrs_src_t;
  typedef enum logic [1:0] {
    MBCRS_T_IDLE = 2'b00, MBCRS_T_WAIT = 2'b01, MBCRS_T_DUMP = 2'b10
  } mbcrs_tstate_t;
endpackage

// File: mbcrs_conv_model.sv
/*
  mbcrs_conv_model: converter seen from the command block.
  Assumes one clock; answers each trigger pulse after 2 or 12 cycles.
*/
`timescale 1ns/10ps
module mbcrs_conv_model
(
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // trigger and pacing
  input wire logic trigger_pulse,
  input wire logic slow,
  input wire logic [31:0] sample,
  // conversion result
  output logic adc_valid,
  output logic [31:0] adc_data,
  output logic converter_idle
);
  logic [3:0] cnt;
  logic [31:0] last;
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt <= 4'h0;
      adc_valid <= 1'b0;
      last <= 32'h0;
    end
    else
    begin
      adc_valid <= (cnt == 4'h1);
      if (cnt == 4'h1)
        last <= sample;
      if (trigger_pulse)
        cnt <= slow ? 4'hC : 4'h2;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end
  // stale data is never shown as valid
  assign adc_data = adc_valid ? last : ~last;
  assign converter_idle = (cnt == 4'h0) && !adc_valid;
endmodule

// File: tb_top.sv
/*
  tb_top: self-checking bench for the meter command block.
  Assumes the converter model beside it and a 25 MHz clock.
*/
`timescale 1ns/10ps
module tb_top
  import mbcrs_pkg::*;
;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0;
  logic [31:0] dat_o;
  logic ack, adc_valid, conv_idle, trig, srq, confl, auto_range;
  logic [31:0] adc_data;
  logic [2:0] range_sel;
  logic slow = 1'b0;
  logic [31:0] smp = 32'h0;
  logic [31:0] rd, rnd, wv, base;
  logic [31:0] sv [3];
  logic [31:0] n_trig = 32'h0;
  logic [31:0] n_conv = 32'h0;
  int n_mismatch = 0;
  int tests_run = 0;
  always #20 clock = ~clock;
  mbcrs_top dut_u(.clock(clock), .rstn(rstn), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .adc_valid(adc_valid), .adc_data(adc_data),
    .converter_idle(conv_idle), .trigger_pulse(trig), .srq(srq),
    .settings_conflict(confl), .range_sel(range_sel),
    .auto_range(auto_range));
  mbcrs_conv_model conv_u(.clock(clock), .rstn(rstn),
    .trigger_pulse(trig), .slow(slow), .sample(smp),
    .adc_valid(adc_valid), .adc_data(adc_data),
    .converter_idle(conv_idle));
  always @(posedge clock)
  begin
    if (trig === 1'b1)
      n_trig <= n_trig + 32'h1;
    if (adc_valid === 1'b1)
      n_conv <= n_conv + 32'h1;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic conflict(input logic [23:0] si,
    input logic [31:0] c);
    logic s;
    s = (si >= 24'h1) && (si <= 24'hE);
    return (s && (c[6:4] == 3'h2 || c[6:4] >= 3'h5 || c[2:0] == 3'h0
      || c[17] || c[10:8] == 3'h5 || c[10:8] == 3'h6))
      || (si >= 24'h1 && si <= 24'h2 && c[10:8] == 3'h4);
  endfunction
  task finish_test;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clock);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task automatic send_wait;
    base = n_conv;
    wr(MBCRS_CMD, 32'h0000_0002);
    for (int n = 0; n < 40 && n_conv == base; n++)
      @(posedge clock);
    if (n_conv == base)
    begin
      n_mismatch++;
      finish_test();
    end
  endtask
  initial
  begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  initial
  begin
    rnd = 32'h0000_0040;
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    chk1(auto_range, 1'b1);
    rd_chk(MBCRS_CTRL, MBCRS_CTRL_RST);
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr(rnd);
      wv = 32'h0000_0500 | {25'h0, 3'(i), 1'b0, rnd[2:0]};
      wr(MBCRS_CTRL, wv);
      repeat (2) @(posedge clock);
      chk1(auto_range, wv[2:0] == 3'h0 || i == 5 || i == 6);
      if (auto_range === 1'b0)
        chk({29'h0, range_sel}, {29'h0, wv[2:0]});
      rd_chk(MBCRS_CTRL, wv);
    end
    wr(MBCRS_STORAGE_INTERVAL, 32'hFFFF_FFFF);
    rd_chk(MBCRS_STORAGE_INTERVAL, 32'h0098_967F);
    for (int i = 0; i < 5; i++)
    begin
      wv = (i == 0) ? 32'h0500 : (i == 3) ? 32'h0521 : 32'h0401;
      base = (i == 0) ? 5 : (i == 1) ? 2 : (i == 2) ? 20 : 14 - i + 3;
      wr(MBCRS_CTRL, wv);
      wr(MBCRS_STORAGE_INTERVAL, base);
      repeat (3) @(posedge clock);
      chk1(confl, conflict(base[23:0], wv));
    end
    wr(MBCRS_CTRL, 32'h0001_1501);
    wr(MBCRS_STORAGE_INTERVAL, 32'h0);
    wr(MBCRS_BUFFER_SIZE_SETTING, 32'h3);
    rd_chk(MBCRS_BUFFER_SIZE_SETTING, 32'h3);
    for (int i = 0; i < 3; i++)
    begin
      rnd = lfsr(rnd);
      sv[i] = rnd;
      smp <= rnd;
      slow <= i[0];
      send_wait();
    end
    repeat (3) @(posedge clock);
    wb(1'b0, MBCRS_STATUS, 32'h0);
    chk1(rd[7], 1'b0);
    for (int i = 0; i < 4; i++)
      rd_chk(MBCRS_TALK, sv[i % 3]);
    wr(MBCRS_CMD, 32'h0000_0004);
    rd_chk(MBCRS_TALK, sv[0]);
    wr(MBCRS_CTRL, 32'h0000_0501);
    rnd = lfsr(rnd);
    smp <= rnd;
    wv = n_trig;
    send_wait();
    repeat (2) @(posedge clock);
    chk(n_trig - wv, 32'h1);
    rd_chk(MBCRS_TALK, rnd);
    wb(1'b0, MBCRS_STATUS, 32'h0);
    chk({28'h0, rd[5:2]}, 32'h0);
    rd_chk(MBCRS_TALK, rnd);
    wr(MBCRS_CTRL, 32'h001C_4501);
    repeat (3) @(posedge clock);
    chk1(srq, 1'b0);
    wb(1'b0, MBCRS_EVENTS, 32'h0);
    chk1(rd[0], 1'b1);
    wr(MBCRS_CTRL, 32'h001C_C501);
    repeat (3) @(posedge clock);
    chk1(srq, 1'b1);
    rd_chk(MBCRS_CTRL, 32'h001C_C501);
    wr(MBCRS_ADCIN, 32'h0000_1234);
    wr(MBCRS_CMD, 32'h0000_0001);
    rd_chk(MBCRS_CTRL, MBCRS_CTRL_RST);
    rd_chk(MBCRS_ADCIN, 32'h0);
    repeat (3) @(posedge clock);
    chk1(srq, 1'b0);
    rd_chk(8'h30, 32'h0);
    finish_test();
  end
endmodule
